// >>> hdl/jdc_pkg.sv
/*
  Constants, register map and types shared by the accessory detection
  control block and its timer.
  Assumes a single 50 MHz clock and a byte-wide register port fed by the
  serial-link slave that sits in front of this block.
*/
package jdc_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h01;
  localparam logic [7:0] ADDR_KEY_STATUS   = 8'h02;
  localparam logic [7:0] ADDR_IRQ_MASK     = 8'h03;
  localparam logic [7:0] ADDR_SETTINGS     = 8'h04;

  // ************************************************************
  // Field positions
  // ************************************************************
  // Event status and per-source masks share bit positions
  localparam int BIT_INS_REM     = 0;
  localparam int BIT_DC          = 1;
  localparam int BIT_CONV        = 2;
  localparam int BIT_GLOBAL_MASK = 3;

  localparam int BIT_SOFT_RESET  = 7;
  localparam int BIT_MANUAL_SW   = 6;
  localparam int BIT_AUTO_DETECT = 5;
  localparam int BIT_DETECT_KICK = 4;
  localparam int BIT_RADIO_PASS  = 3;
  localparam int DEBOUNCE_MSB    = 2;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [3:0] IRQ_MASK_RESET    = 4'h8;
  localparam logic       AUTO_DETECT_RESET = 1'b1;
  localparam logic [2:0] DEBOUNCE_RESET    = 3'h3;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_HZ        = 50000000;
  localparam int TICK_MS       = 1;
  localparam int CYCLES_PER_MS = CLK_HZ / 1000 * TICK_MS;
  localparam int DEBOUNCE_W    = 11;

  // Insertion debounce time in milliseconds per field code
  function automatic logic [DEBOUNCE_W-1:0] debounce_ms(input logic [2:0] code);
    logic [DEBOUNCE_W-1:0] ms;
    ms = 11'h002;
    unique case (code)
      3'h0: ms = 11'h002;
      3'h1: ms = 11'h01e;
      3'h2: ms = 11'h03c;
      3'h3: ms = 11'h05a;
      3'h4: ms = 11'h078;
      3'h5: ms = 11'h096;
      3'h6: ms = 11'h3e8;
      3'h7: ms = 11'h7d0;
    endcase
    return ms;
  endfunction

  typedef enum logic {DET_IDLE, DET_BUSY} detect_state_t;

endpackage

// >>> hdl/event_timer.sv
/*
  Down-counting timer advanced by a one-cycle tick enable.
  Assumes the caller holds load high while the timed condition is absent.
*/
`timescale 1ns/100ps
module event_timer #(
  parameter int WIDTH = 11
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  input  wire logic             tick,
  output logic                  expired
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic             expired_next;

  always_comb begin
    count_next   = count_reg;
    expired_next = 1'b0;
    if (load) begin
      count_next = load_value;
    end else if (tick && count_reg != '0) begin
      count_next = count_reg - WIDTH'(1);
      // Fire once on the last tick, then sit idle at zero
      expired_next = (count_reg == WIDTH'(1));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      count_reg <= '0;
      expired   <= 1'b0;
    end else begin
      count_reg <= count_next;
      expired   <= expired_next;
    end
  end

endmodule

// >>> hdl/jack_detect_ctrl.sv
/*
  Interrupt masking, event status and device settings of an audio
  accessory detection switch, with insertion debounce and detection
  sequencing control.
  Assumes a serial-link slave in front that turns each register transfer
  into a one-cycle byte strobe, and an analog detection engine that
  reports completion with a one-cycle pulse. All inputs are synchronous
  to sys_clk.
*/
`timescale 1ns/100ps

// Contract
// [RQ1] Global mask blocks interrupt, status still updates
// [RQ2] Conversion mask blocks interrupt, status still sets
// [RQ3] Key press interrupts despite conversion mask
// [RQ4] DC mask blocks interrupt, status still sets
// [RQ5] Plug mask blocks interrupt, status still sets
// [RQ6] Soft reset bit resets device, aborts work
// [RQ7] Override makes switches follow control registers
// [RQ8] Auto detect enable gates detection after insertion
// [RQ9] Kick starts detection, clears when done
// [RQ10] Kick ignored while detection busy
// [RQ11] Kick ignored while key status nonzero
// [RQ12] Kick ignored when jack sense high
// [RQ13] Radio pass turns depletion transistors off; the code does so only while plugged
// [RQ14] Key status clears on read or disable
// [RQ15] Three-bit insertion debounce select, default 90 ms
// [RQ16] Interrupt low while any unmasked status set
module jack_detect_ctrl #(
  parameter int CYCLES_PER_MS = jdc_pkg::CYCLES_PER_MS,
  parameter int KEY_W         = 8,
  parameter int SW_W          = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  // Byte register port from the serial-link slave
  input  wire logic [7:0]       reg_addr,
  input  wire logic             reg_wr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_rd,
  output logic [7:0]            reg_rdata,
  // Accessory and analog side
  input  wire logic             jack_sense_n,
  input  wire logic             conv_done,
  input  wire logic             dc_event,
  input  wire logic [KEY_W-1:0] key_event,
  input  wire logic             key_scan_enable,
  input  wire logic             detect_done,
  input  wire logic [SW_W-1:0]  switch_ctrl,
  input  wire logic [SW_W-1:0]  switch_auto,
  output logic                  detect_start,
  output logic                  detect_abort,
  output logic [SW_W-1:0]       switch_state,
  output logic                  manual_switch,
  output logic                  depletion_off,
  output logic                  plugged,
  output logic                  irq_n
);

  // ************************************************************
  // Software reset
  // ************************************************************
  logic soft_reset_reg;
  logic soft_reset_next;
  logic core_rstn;

  // A write of one lands in the next cycle and holds the core in reset
  // for exactly one cycle; the bit itself always reads back zero.
  assign core_rstn = rstn && !soft_reset_reg; // RQ6

  always_comb begin
    soft_reset_next = reg_wr && reg_addr == jdc_pkg::ADDR_SETTINGS &&
                      reg_wdata[jdc_pkg::BIT_SOFT_RESET]; // RQ6
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= soft_reset_next;
    end
  end

  // ************************************************************
  // Millisecond tick and insertion debounce
  // ************************************************************
  localparam int TICK_W = $clog2(CYCLES_PER_MS);

  logic [TICK_W-1:0] tick_cnt_reg;
  logic [TICK_W-1:0] tick_cnt_next;
  logic              ms_tick;
  logic              sense_in_reg;
  logic              plugged_next;
  logic              debounce_done;
  logic              sense_stable;
  logic [2:0]        debounce_sel_reg;

  // The tick runs free, so a debounce wait may come up to one tick short
  always_comb begin
    ms_tick       = (tick_cnt_reg == TICK_W'(CYCLES_PER_MS - 1));
    tick_cnt_next = ms_tick ? '0 : tick_cnt_reg + TICK_W'(1);
    // Timer reloads while the sensed level agrees with the plug state
    sense_stable  = (!sense_in_reg == plugged);
    plugged_next  = debounce_done ? !sense_in_reg : plugged;
  end

  always_ff @(posedge sys_clk) begin
    if (!core_rstn) begin
      tick_cnt_reg <= '0;
      sense_in_reg <= 1'b1;
      plugged      <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      sense_in_reg <= jack_sense_n;
      plugged      <= plugged_next;
    end
  end

  // Change must persist for the selected time before it counts
  event_timer #(
    .WIDTH      (jdc_pkg::DEBOUNCE_W)
  ) u_insert_debounce (
    .sys_clk    (sys_clk),
    .rstn       (core_rstn),
    .load       (sense_stable),
    .load_value (jdc_pkg::debounce_ms(debounce_sel_reg)), // RQ15
    .tick       (ms_tick),
    .expired    (debounce_done)
  );

  // ************************************************************
  // Registers and status
  // ************************************************************
  logic [3:0]       irq_mask_reg;
  logic [3:0]       irq_mask_next;
  logic             manual_sw_reg;
  logic             manual_sw_next;
  logic             auto_detect_reg;
  logic             auto_detect_next;
  logic             detect_kick_reg;
  logic             detect_kick_next;
  logic             radio_pass_reg;
  logic             radio_pass_next;
  logic [2:0]       debounce_sel_next;
  logic [2:0]       event_status_reg;
  logic [2:0]       event_status_next;
  logic [2:0]       event_set;
  logic [KEY_W-1:0] key_status_reg;
  logic [KEY_W-1:0] key_status_next;
  logic [7:0]       rdata_next;
  logic             wr_mask;
  logic             wr_settings;
  logic             rd_event;
  logic             rd_key;
  logic             kick_req;
  logic             kick_ok;
  logic             auto_start;
  logic             irq_n_next;

  jdc_pkg::detect_state_t det_state_reg;
  jdc_pkg::detect_state_t det_state_next;
  logic                   detect_start_next;
  logic                   detect_abort_next;

  always_comb begin
    wr_mask     = reg_wr && reg_addr == jdc_pkg::ADDR_IRQ_MASK;
    wr_settings = reg_wr && reg_addr == jdc_pkg::ADDR_SETTINGS;
    rd_event    = reg_rd && reg_addr == jdc_pkg::ADDR_EVENT_STATUS;
    rd_key      = reg_rd && reg_addr == jdc_pkg::ADDR_KEY_STATUS;
    kick_req    = wr_settings && reg_wdata[jdc_pkg::BIT_DETECT_KICK]; // RQ9
    // Kick is dropped when busy, keys pending or nothing inserted
    kick_ok     = kick_req && det_state_reg == jdc_pkg::DET_IDLE && // RQ10
                  key_status_reg == '0 && // RQ11
                  !jack_sense_n; // RQ12
    // Only an insertion may start a run by itself, never a removal
    auto_start  = debounce_done && !sense_in_reg && auto_detect_reg; // RQ8

    irq_mask_next     = irq_mask_reg;
    manual_sw_next    = manual_sw_reg;
    auto_detect_next  = auto_detect_reg;
    radio_pass_next   = radio_pass_reg;
    debounce_sel_next = debounce_sel_reg;
    if (wr_mask) begin
      irq_mask_next = reg_wdata[3:0];
    end
    // A soft reset write lands here too, then the reset overwrites it
    if (wr_settings) begin
      manual_sw_next    = reg_wdata[jdc_pkg::BIT_MANUAL_SW];
      auto_detect_next  = reg_wdata[jdc_pkg::BIT_AUTO_DETECT];
      radio_pass_next   = reg_wdata[jdc_pkg::BIT_RADIO_PASS];
      debounce_sel_next = reg_wdata[jdc_pkg::DEBOUNCE_MSB:0]; // RQ15
    end

    // Status keeps collecting regardless of any mask; a new event in the
    // cycle of a clearing read survives the read.
    event_set = '0;
    // Insertion and removal share one status bit
    event_set[jdc_pkg::BIT_INS_REM] = debounce_done; // RQ5
    event_set[jdc_pkg::BIT_DC]      = dc_event; // RQ4
    event_set[jdc_pkg::BIT_CONV]    = conv_done; // RQ2
    event_status_next = (rd_event ? 3'h0 : event_status_reg) | event_set; // RQ1
    if (!key_scan_enable) begin
      // Disable wins over a press in the same cycle
      key_status_next = '0; // RQ14
    end else begin
      key_status_next = (rd_key ? '0 : key_status_reg) | key_event; // RQ14
    end

    // Detection sequencing; removal or completion ends a run
    det_state_next    = det_state_reg;
    detect_kick_next  = detect_kick_reg;
    detect_start_next = 1'b0;
    detect_abort_next = 1'b0;
    unique case (det_state_reg)
      jdc_pkg::DET_IDLE: begin
        if (kick_ok || auto_start) begin
          det_state_next    = jdc_pkg::DET_BUSY;
          detect_start_next = 1'b1;
          detect_kick_next  = kick_ok; // RQ9
        end
      end
      jdc_pkg::DET_BUSY: begin
        // Completion wins over a removal seen in the same cycle
        if (detect_done) begin
          det_state_next   = jdc_pkg::DET_IDLE;
          detect_kick_next = 1'b0; // RQ9
        end else if (debounce_done && sense_in_reg) begin
          det_state_next    = jdc_pkg::DET_IDLE;
          detect_kick_next  = 1'b0;
          detect_abort_next = 1'b1;
        end
      end
    endcase

    // Key events are never masked per source, only globally
    irq_n_next = !(!irq_mask_reg[jdc_pkg::BIT_GLOBAL_MASK] && // RQ1
                   ((|(event_status_reg & ~irq_mask_reg[2:0])) || // RQ16
                    (|key_status_reg))); // RQ3

    // Reserved bits and the reset bit always read back as zero
    rdata_next = 8'h00;
    unique case (reg_addr)
      jdc_pkg::ADDR_EVENT_STATUS: rdata_next = {5'h00, event_status_reg};
      jdc_pkg::ADDR_KEY_STATUS:   rdata_next = 8'(key_status_reg);
      jdc_pkg::ADDR_IRQ_MASK:     rdata_next = {4'h0, irq_mask_reg};
      jdc_pkg::ADDR_SETTINGS:     rdata_next = {1'b0, manual_sw_reg, auto_detect_reg,
                                                detect_kick_reg, radio_pass_reg,
                                                debounce_sel_reg};
      default:                    rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!core_rstn) begin
      irq_mask_reg     <= jdc_pkg::IRQ_MASK_RESET; // RQ1
      manual_sw_reg    <= 1'b0; // RQ7
      auto_detect_reg  <= jdc_pkg::AUTO_DETECT_RESET; // RQ8
      detect_kick_reg  <= 1'b0;
      radio_pass_reg   <= 1'b0;
      debounce_sel_reg <= jdc_pkg::DEBOUNCE_RESET; // RQ15
      event_status_reg <= '0;
      key_status_reg   <= '0;
      det_state_reg    <= jdc_pkg::DET_IDLE; // RQ6
      detect_start     <= 1'b0;
      // A soft reset tells the engine to drop its run
      detect_abort     <= !rstn ? 1'b0 : 1'b1; // RQ6
      reg_rdata        <= 8'h00;
      irq_n            <= 1'b1;
    end else begin
      irq_mask_reg     <= irq_mask_next;
      manual_sw_reg    <= manual_sw_next;
      auto_detect_reg  <= auto_detect_next;
      detect_kick_reg  <= detect_kick_next;
      radio_pass_reg   <= radio_pass_next;
      debounce_sel_reg <= debounce_sel_next;
      event_status_reg <= event_status_next;
      key_status_reg   <= key_status_next;
      det_state_reg    <= det_state_next;
      detect_start     <= detect_start_next;
      detect_abort     <= detect_abort_next;
      reg_rdata        <= reg_rd ? rdata_next : reg_rdata;
      irq_n            <= irq_n_next; // RQ16
    end
  end

  // ************************************************************
  // Switch and transistor drive
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (!core_rstn) begin
      switch_state  <= '0;
      manual_switch <= 1'b0;
      depletion_off <= 1'b0;
    end else begin
      switch_state  <= manual_sw_reg ? switch_ctrl : switch_auto; // RQ7
      manual_switch <= manual_sw_reg;
      // Transistors stay on whenever nothing is inserted
      depletion_off <= radio_pass_reg && plugged; // RQ13
    end
  end

endmodule

// >>> verif/detect_engine_model.sv
/*
  Behavioural detection engine: ends each run after a settable delay.
  Assumes delay is at least 1 and that an abort cancels the run.
*/
`timescale 1ns/100ps
module detect_engine_model (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       detect_start,
  input  wire logic       detect_abort,
  input  wire logic [7:0] delay,
  output logic            detect_done
);
  logic [7:0] cnt;
  always @(posedge sys_clk) begin
    detect_done <= 1'b0;
    if (!rstn || detect_abort) cnt <= 8'h00;
    else if (detect_start) cnt <= delay;
    else if (cnt == 8'h01) begin
      cnt <= 8'h00;
      detect_done <= 1'b1;
    end else if (cnt != 8'h00) cnt <= cnt - 8'h01;
  end
endmodule

// >>> verif/jack_detect_ctrl_assertions.sv
/*
  Port checker for the detection control block.
  Assumes the mask register changes only by host writes or resets.
*/
`timescale 1ns/100ps
module jack_detect_ctrl_assertions (
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       jack_sense_n,
  input wire logic       dc_event,
  input wire logic [7:0] switch_ctrl,
  input wire logic [7:0] switch_auto,
  input wire logic       detect_start,
  input wire logic       detect_abort,
  input wire logic [7:0] switch_state,
  input wire logic       manual_switch,
  input wire logic       depletion_off,
  input wire logic       plugged,
  input wire logic       irq_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Shadow of the mask, so interrupt relations need no internal probes
  logic [3:0] m;
  always_ff @(posedge sys_clk) begin
    if (!rstn) m <= 4'h8;
    else if (reg_wr && reg_addr == jdc_pkg::ADDR_IRQ_MASK) m <= reg_wdata[3:0];
    else if (reg_wr && reg_addr == jdc_pkg::ADDR_SETTINGS && reg_wdata[7]) m <= 4'h8;
  end
  property p_irq_rst; !$past(rstn) |-> irq_n; endproperty
  property p_irq_masked; m[3] [*3] |-> irq_n; endproperty
  property p_dc_irq; m == 4'h0 && $past(m) == 4'h0 && dc_event |-> ##[1:3] !irq_n;
  endproperty
  property p_start; detect_start |=> !detect_start; endproperty
  property p_abort; detect_abort |=> !detect_abort; endproperty
  property p_kick_sense;
    reg_wr && reg_addr == jdc_pkg::ADDR_SETTINGS && reg_wdata[4] && jack_sense_n && !plugged
      |=> !detect_start [*2];
  endproperty
  property p_sw_follow;
    $past(rstn) && !detect_abort && $stable(manual_switch)
      |-> switch_state == (manual_switch ? $past(switch_ctrl) : $past(switch_auto));
  endproperty
  property p_depl; depletion_off |-> plugged || $past(plugged); endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("irq low after reset");
  a_irq_masked: assert property (p_irq_masked) else $error("irq under global mask");
  a_dc_irq: assert property (p_dc_irq) else $error("dc event gave no irq");
  a_start: assert property (p_start) else $error("start pulse too long");
  a_abort: assert property (p_abort) else $error("abort pulse too long");
  a_kick_sense: assert property (p_kick_sense) else $error("kick taken unplugged");
  a_sw_follow: assert property (p_sw_follow) else $error("switch state wrong");
  a_depl: assert property (p_depl) else $error("depletion off unplugged");
  c_start: cover property (detect_start);
  c_abort: cover property (detect_abort);
  c_irq: cover property (!irq_n);
endmodule
bind jack_detect_ctrl jack_detect_ctrl_assertions i_jack_detect_ctrl_assertions (.*);

// >>> verif/test_jack_detect_ctrl.sv
/*
  Self-checking bench for the detection control block.
  Assumes 10 clock cycles per ms tick to keep debounce waits short.
*/
`timescale 1ns/100ps
module test_jack_detect_ctrl;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic       sys_clk, rstn, reg_wr, reg_rd, jack_sense_n, conv_done, dc_event;
  logic       key_scan_enable, detect_done, detect_start, detect_abort;
  logic       manual_switch, depletion_off, plugged, irq_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, key_event, switch_ctrl, switch_auto;
  logic [7:0] switch_state, dly;
  int         mismatches, comparisons, starts, aborts;
  jack_detect_ctrl #(.CYCLES_PER_MS(10)) i_jack_detect_ctrl (.*);
  detect_engine_model i_detect_engine_model (.sys_clk(sys_clk), .rstn(rstn),
    .detect_start(detect_start), .detect_abort(detect_abort), .delay(dly),
    .detect_done(detect_done));
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (detect_start === 1'b1) starts++;
    if (detect_abort === 1'b1) aborts++;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic complete_run;
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge sys_clk) reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk) {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge sys_clk) reg_rd = 1'b0;
    chk(reg_rdata, e);
  endtask
  task automatic ev(input logic c, input logic d, input logic [7:0] k);
    @(negedge sys_clk) {conv_done, dc_event, key_event} = {c, d, k};
    @(negedge sys_clk) {conv_done, dc_event, key_event} = 10'h000;
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic plug(input logic v, input int e);
    int n;
    jack_sense_n = ~v;
    for (n = 0; n < e * 10 + 40 && plugged !== v; n++) @(negedge sys_clk);
    chk({7'h00, n >= e * 10 - 10 && n <= e * 10 + 3}, 8'h01);
    repeat (4) @(negedge sys_clk);
    chk({7'h00, plugged}, {7'h00, v});
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_reset;
    chk({7'h00, irq_n}, 8'h01);
    rd(8'h03, 8'h08);
    rd(8'h04, 8'h23);
  endtask
  task automatic s_auto_plug;
    wr(8'h04, 8'h20);
    wr(8'h03, 8'h00);
    plug(1'b1, 2);
    chk(starts[7:0], 8'h01);
    chk({7'h00, irq_n}, 8'h00);
    rd(8'h01, 8'h01);
    rd(8'h01, 8'h00);
  endtask
  task automatic s_kick_busy;
    dly = 8'h28;
    wr(8'h04, 8'h30);
    repeat (2) @(negedge sys_clk);
    chk(starts[7:0], 8'h02);
    rd(8'h04, 8'h30);
    wr(8'h04, 8'h30);
    repeat (2) @(negedge sys_clk);
    chk(starts[7:0], 8'h02);
    repeat (50) @(negedge sys_clk);
    rd(8'h04, 8'h20);
  endtask
  task automatic s_kick_keys;
    ev(1'b0, 1'b0, 8'h01);
    wr(8'h04, 8'h30);
    repeat (2) @(negedge sys_clk);
    chk(starts[7:0], 8'h02);
    rd(8'h02, 8'h01);
    rd(8'h02, 8'h00);
    ev(1'b0, 1'b0, 8'h02);
    @(negedge sys_clk) key_scan_enable = 1'b0;
    rd(8'h02, 8'h00);
    key_scan_enable = 1'b1;
  endtask
  task automatic s_masks;
    ev(1'b0, 1'b1, 8'h00);
    chk({7'h00, irq_n}, 8'h00);
    rd(8'h01, 8'h02);
    wr(8'h03, 8'h07);
    ev(1'b1, 1'b1, 8'h00);
    chk({7'h00, irq_n}, 8'h01);
    rd(8'h01, 8'h06);
    ev(1'b0, 1'b0, 8'h04);
    chk({7'h00, irq_n}, 8'h00);
    rd(8'h02, 8'h04);
    ev(1'b1, 1'b0, 8'h00);
    chk({7'h00, irq_n}, 8'h01);
    rd(8'h01, 8'h04);
    wr(8'h03, 8'h08);
    ev(1'b0, 1'b1, 8'h00);
    chk({7'h00, irq_n}, 8'h01);
    rd(8'h01, 8'h02);
  endtask
  task automatic s_switches;
    chk(switch_state, 8'h5a);
    wr(8'h04, 8'h68);
    repeat (2) @(negedge sys_clk);
    chk(switch_state, 8'ha5);
    chk({6'h00, manual_switch, depletion_off}, 8'h03);
    wr(8'h04, 8'h20);
    repeat (2) @(negedge sys_clk);
    chk({6'h00, manual_switch, depletion_off}, 8'h00);
  endtask
  task automatic s_unplug;
    wr(8'h03, 8'h01);
    plug(1'b0, 2);
    chk({7'h00, irq_n}, 8'h01);
    rd(8'h01, 8'h01);
    wr(8'h04, 8'h30);
    repeat (2) @(negedge sys_clk);
    chk(starts[7:0], 8'h02);
    wr(8'h04, 8'h00);
    plug(1'b1, 2);
    chk(starts[7:0], 8'h02);
  endtask
  task automatic s_soft_reset;
    dly = 8'hc8;
    wr(8'h03, 8'h01);
    wr(8'h04, 8'h10);
    wr(8'h04, 8'h80);
    repeat (3) @(negedge sys_clk);
    chk(aborts[7:0], 8'h01);
    rd(8'h04, 8'h23);
    rd(8'h03, 8'h08);
    plug(1'b1, 90);
    chk(starts[7:0], 8'h04);
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    {sys_clk, rstn, reg_wr, reg_rd, conv_done, dc_event} = 6'h00;
    {reg_addr, reg_wdata, key_event} = 24'h000000;
    {jack_sense_n, key_scan_enable} = 2'b11;
    {switch_ctrl, switch_auto, dly} = 24'ha55a02;
    {mismatches, comparisons, starts, aborts} = '0;
    repeat (12) @(negedge sys_clk);
    rstn = 1'b1;
    s_reset;
    s_auto_plug;
    s_kick_busy;
    s_kick_keys;
    s_masks;
    s_switches;
    s_unplug;
    s_soft_reset;
    complete_run;
  end
  initial begin
    #400000;
    mismatches++;
    complete_run;
  end
endmodule
